// *** hdl/irq_status_pkg.sv ***
package irq_status_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [11:0] ICR_OFS = 12'h050;
   localparam logic [31:0] ICR_RESET = 32'h0000_0000;

   // ****************************************************************
   // field positions inside the register word
   // ****************************************************************
   localparam int EVT_LO_POS = 0;    // event flags 7:0
   localparam int EN_LO_POS = 8;     // enables for flags 7:0
   localparam int EVT_HI_POS = 16;   // channel three and four done
   localparam int EN_HI_POS = 18;    // their enables
   localparam int CLR_HI_POS = 20;   // their write-one clears
   localparam int UART_FLAG_POS = 22;
   localparam int UART_GATE_POS = 23;
   localparam int CLR_LO_POS = 24;   // write-one clears for flags 7:0

   // ****************************************************************
   // event counts and bus answers
   // ****************************************************************
   localparam int EVT_LO_N = 8;
   localparam int EVT_HI_N = 2;
   localparam int EVT_N = EVT_LO_N + EVT_HI_N;
   localparam int UART_SRC_N = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ****************************************************************
   // carriers
   // ****************************************************************
   // one-cycle event pulses from the surrounding controller
   typedef struct packed {
      logic cpu_bus_err;       // error on a processor access
      logic [3:0] dma_done;    // [0] is channel one
      logic [1:0] mbox_hit;    // [0] is mailbox one, from the pci side
      logic dma_bus_err;       // any bus error caused by the dma engine
      logic pci_target_miss;   // target window hit, no resource behind it
      logic par_addr_tgt;      // address parity, target cycle
      logic par_data_tgt_wr;   // data parity, target write
      logic par_data_mst_rd;   // data parity, master read
   } event_in_t;

   // level state of the serial port interrupt logic
   typedef struct packed {
      logic raw_irq;
      logic [UART_SRC_N-1:0] serial_source_enable_reg;
   } uart_in_t;

endpackage

// *** hdl/sticky_flag_bank.sv ***
`timescale 1ns/1ps
module sticky_flag_bank
   import irq_status_pkg::*;
#(
   parameter int N = EVT_N
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [N-1:0] set_pulse,
   input wire logic [N-1:0] clr_pulse,
   output logic [N-1:0] flags
);

   // ****************************************************************
   // elaboration check
   // ****************************************************************
   generate
      if (N < 1) begin : g_bad_n
         $error("sticky_flag_bank needs at least one flag");
      end
   endgenerate

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [N-1:0] flag;
   } bank_state_t;

   bank_state_t state_r;
   bank_state_t state_nxt;

   // each flag holds until cleared; a set in the clear cycle survives
   always_comb begin
      state_nxt = state_r;
      for (int i = 0; i < N; i++) begin
         if (set_pulse[i]) begin
            state_nxt.flag[i] = 1'b1;
         end else if (clr_pulse[i]) begin
            state_nxt.flag[i] = 1'b0;
         end
      end
   end

   // synchronous reset to all clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign flags = state_r.flag;

endmodule // sticky_flag_bank

// *** hdl/bus_error_dma_interrupt_status.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module bus_error_dma_interrupt_status
   import irq_status_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // event sources and serial port
   input wire event_in_t events,
   input wire uart_in_t uart_in,
   // maskable interrupt to the processor
   output logic irq_level
);

   // ****************************************************************
   // elaboration check
   // ****************************************************************
   // the register must be reachable, so the bus needs its offset bits
   generate
      if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
         $error("ADDR_W must lie between 8 and 32");
      end
      // the offset must survive the cut to the bus width
      if ((ICR_OFS >> ADDR_W) != 0) begin : g_bad_ofs
         $error("register offset does not fit ADDR_W");
      end
      // flags and enables of the low byte sit side by side, clears on top
      if (EN_LO_POS != EVT_LO_POS + EVT_LO_N || CLR_LO_POS + EVT_LO_N > 32) begin : g_bad_lo
         $error("low field layout does not fit the word");
      end
      // channel three and four fields follow each other without gaps
      if (EN_HI_POS != EVT_HI_POS + EVT_HI_N || CLR_HI_POS != EN_HI_POS + EVT_HI_N) begin : g_bad_hi
         $error("high field layout does not fit the word");
      end
      // serial flag and gate must stay below the clear byte
      if (UART_GATE_POS != UART_FLAG_POS + 1 || UART_GATE_POS >= CLR_LO_POS) begin : g_bad_uart
         $error("serial fields collide with the clear byte");
      end
   endgenerate

   // ****************************************************************
   // decode and readback helpers
   // ****************************************************************
   // word compare; the low two bits of the byte address are ignored
   function automatic logic icr_hit(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] ofs;
      ofs = ADDR_W'(ICR_OFS);
      icr_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

   // the word as software sees it; clear bits never read back
   function automatic logic [31:0] icr_image(
      input logic [EVT_N-1:0] flg,
      input logic [EVT_N-1:0] ena,
      input logic uart_act,
      input logic gate
   );
      logic [31:0] img;
      img = ICR_RESET;
      img[EVT_LO_POS +: EVT_LO_N] = flg[EVT_LO_N-1:0];
      img[EN_LO_POS +: EVT_LO_N] = ena[EVT_LO_N-1:0];
      img[EVT_HI_POS +: EVT_HI_N] = flg[EVT_N-1:EVT_LO_N];
      img[EN_HI_POS +: EVT_HI_N] = ena[EVT_N-1:EVT_LO_N];
      img[UART_FLAG_POS] = uart_act;
      img[UART_GATE_POS] = gate;
      // bits 21:20 and 31:24 stay zero here
      icr_image = img;
   endfunction

   // one byte lane of a write that commits to this register
   function automatic logic lane_wr(input logic hit, input logic [3:0] strb, input int lane);
      lane_wr = hit && strb[lane];
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   // bus holding, enables and the registered line share one struct
   typedef struct packed {
      logic aw_full;
      logic [ADDR_W-1:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [EVT_N-1:0] enable;
      logic uart_gate;
      logic irq;
   } ctl_state_t;

   ctl_state_t state_r;
   ctl_state_t state_nxt;

   // ****************************************************************
   // event mapping
   // ****************************************************************
   logic [EVT_N-1:0] set_vec;
   logic [EVT_N-1:0] clr_vec;
   logic [EVT_N-1:0] flag_vec;
   logic uart_active;
   logic par_any;

   // three parity checks share one flag; which one fired is not kept
   assign par_any = events.par_addr_tgt | events.par_data_tgt_wr | events.par_data_mst_rd;

   // one pulse per cause, all from this clock, so no synchroniser
   always_comb begin
      set_vec = '0;
      set_vec[0] = events.cpu_bus_err;
      set_vec[1] = events.dma_done[0];
      set_vec[2] = events.dma_done[1];
      set_vec[3] = events.mbox_hit[0];
      set_vec[4] = events.mbox_hit[1];
      set_vec[5] = events.dma_bus_err;
      set_vec[6] = events.pci_target_miss;
      set_vec[7] = par_any;
      set_vec[8] = events.dma_done[2];
      set_vec[9] = events.dma_done[3];
   end

   // serial port request is live only while some source is enabled
   assign uart_active = uart_in.raw_irq & (|uart_in.serial_source_enable_reg);

   // ****************************************************************
   // event flag storage
   // ****************************************************************
   // a set arriving with its clear wins, so no event is lost
   sticky_flag_bank #(
      .N(EVT_N)
   ) u_flags (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .set_pulse(set_vec),
      .clr_pulse(clr_vec),
      .flags(flag_vec)
   );

   // ****************************************************************
   // interrupt pending terms
   // ****************************************************************
   // one term per flag and enable pair; no order is kept between them
   wire logic [EVT_N-1:0] pend_vec;
   logic uart_pend;

   generate
      for (genvar g = 0; g < EVT_N; g++) begin : g_pend
         assign pend_vec[g] = flag_vec[g] & state_r.enable[g];
      end
   endgenerate

   // the serial port counts as one more pair behind its global gate
   assign uart_pend = uart_active & state_r.uart_gate;

   // ****************************************************************
   // read image
   // ****************************************************************
   // built every cycle, captured only on the address handshake; bit 22
   // is live, so a read shows the serial state of that very edge
   logic rd_map_hit;
   logic [31:0] rd_word;

   assign rd_map_hit = icr_hit(araddr);
   assign rd_word = rd_map_hit ?
      icr_image(flag_vec, state_r.enable, uart_active, state_r.uart_gate) : 32'h0000_0000;

   // ****************************************************************
   // axi handshakes
   // ****************************************************************
   // address and data are held apart so either may come first;
   // no new write is taken while a response waits
   assign awready = !state_r.aw_full && !state_r.bvalid;
   assign wready = !state_r.w_full && !state_r.bvalid;
   assign arready = !state_r.rvalid;

   logic aw_take;
   logic w_take;
   logic ar_take;
   logic aw_have;
   logic w_have;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_go;
   logic wr_hit;

   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign ar_take = arvalid && arready;
   assign aw_have = state_r.aw_full || aw_take;
   assign w_have = state_r.w_full || w_take;
   assign wr_go = aw_have && w_have;

   // use the held copy if there is one, else the bus value
   assign wr_addr = state_r.aw_full ? state_r.aw_addr : awaddr;
   assign wr_data = state_r.w_full ? state_r.w_data : wdata;
   assign wr_strb = state_r.w_full ? state_r.w_strb : wstrb;
   assign wr_hit = wr_go && icr_hit(wr_addr);

   // ****************************************************************
   // write-one clears
   // ****************************************************************
   // only lanes whose strobe is set may clear; zeros do nothing
   // a clear meeting a new event loses; the flag waits for the next write-one clear
   always_comb begin
      clr_vec = '0;
      if (lane_wr(wr_hit, wr_strb, 3)) begin
         clr_vec[EVT_LO_N-1:0] = wr_data[CLR_LO_POS +: EVT_LO_N];
      end
      if (lane_wr(wr_hit, wr_strb, 2)) begin
         clr_vec[EVT_N-1:EVT_LO_N] = wr_data[CLR_HI_POS +: EVT_HI_N];
      end
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;

      // hold whichever half of a write arrived alone
      if (aw_take) begin
         state_nxt.aw_full = 1'b1;
         state_nxt.aw_addr = awaddr;
      end
      if (w_take) begin
         state_nxt.w_full = 1'b1;
         state_nxt.w_data = wdata;
         state_nxt.w_strb = wstrb;
      end

      // response retires on bready
      if (state_r.bvalid && bready) begin
         state_nxt.bvalid = 1'b0;
      end

      // both halves present: commit and answer
      if (wr_go) begin
         state_nxt.aw_full = 1'b0;
         state_nxt.w_full = 1'b0;
         state_nxt.bvalid = 1'b1;
         state_nxt.bresp = wr_hit ? RESP_OKAY : RESP_DECERR;
      end

      // enables live in the read/write middle bytes only
      if (lane_wr(wr_hit, wr_strb, 1)) begin
         state_nxt.enable[EVT_LO_N-1:0] = wr_data[EN_LO_POS +: EVT_LO_N];
      end
      if (lane_wr(wr_hit, wr_strb, 2)) begin
         state_nxt.enable[EVT_N-1:EVT_LO_N] = wr_data[EN_HI_POS +: EVT_HI_N];
         state_nxt.uart_gate = wr_data[UART_GATE_POS];
      end
      // writes to the low byte land nowhere: those bits are read-only

      // read data is captured on the address handshake
      if (state_r.rvalid && rready) begin
         state_nxt.rvalid = 1'b0;
      end
      // an unmapped read answers an error and carries zero data
      if (ar_take) begin
         state_nxt.rvalid = 1'b1;
         state_nxt.rdata = rd_word;
         state_nxt.rresp = rd_map_hit ? RESP_OKAY : RESP_DECERR;
      end

      // a write and a read may commit together; they share no field
      // one level for every cause, no ordering between them; the
      // register stage costs a cycle but keeps the pin glitch free
      state_nxt.irq = (|pend_vec) || uart_pend;
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // all fields zero after reset, the interrupt line included
   // a reset in mid-write drops the held half without an answer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // answers and the line come straight from flops; readies are combinational
   assign bvalid = state_r.bvalid;
   assign bresp = state_r.bresp;
   assign rvalid = state_r.rvalid;
   assign rdata = state_r.rdata;
   assign rresp = state_r.rresp;
   assign irq_level = state_r.irq;

endmodule // bus_error_dma_interrupt_status

// *** testbench/irq_status_props.sv ***
`timescale 1ns/1ps
module irq_status_props
   import irq_status_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire event_in_t events,
   input wire uart_in_t uart_in,
   input wire logic irq_level
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // read accepted at the one mapped word; low address bits ignored
   wire logic rd_hit = arvalid && arready && ((araddr >> 2) == ADDR_W'(ICR_OFS >> 2));

   property p_reset_quiet;
      $fell(sys_rst) |-> !irq_level && !bvalid && !rvalid;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
   property p_write_answer;
      awvalid && awready && wvalid && wready |=> bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write response");
   property p_write_refused;
      bvalid && !bready |=> bvalid && $stable(bresp) && !awready && !wready;
   endproperty
   a_write_refused: assert property (p_write_refused) else $error("write response not held");
   property p_read_zero_fields;
      rd_hit |=> rvalid && rresp == RESP_OKAY && rdata[31:24] == 8'h00 && rdata[21:20] == 2'b00;
   endproperty
   a_read_zero_fields: assert property (p_read_zero_fields) else $error("clear bits read nonzero");
   property p_read_unmapped;
      arvalid && arready && !rd_hit |=> rresp == RESP_DECERR && rdata == 32'h0000_0000;
   endproperty
   a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read answered");
   property p_uart_off;
      rd_hit && uart_in.serial_source_enable_reg == 4'h0 |=> !rdata[22];
   endproperty
   a_uart_off: assert property (p_uart_off) else $error("serial flag without sources");
   property p_uart_live;
      rd_hit && uart_in.raw_irq && uart_in.serial_source_enable_reg != 4'h0 |=> rdata[22];
   endproperty
   a_uart_live: assert property (p_uart_live) else $error("serial flag missing");
   property p_read_hold;
      rvalid && !rready |=> rvalid && $stable(rdata) && !arready;
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read data not held");
   // no committed write and no serial cause: nothing may lower the line
   property p_irq_hold;
      irq_level && !uart_in.raw_irq && !$past(uart_in.raw_irq) && !$rose(bvalid) |=> irq_level;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without clear");
endmodule // irq_status_props

bind bus_error_dma_interrupt_status irq_status_props #(.ADDR_W(ADDR_W)) irq_status_props_i (
   .core_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
   .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
   .events, .uart_in, .irq_level
);

// *** testbench/irq_host_model.sv ***
`timescale 1ns/1ps
module irq_host_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic irq_level,
   output logic [7:0] rise_cnt
);
   logic last_r;
   // count each new level assertion; level line, so one cause run is one rise
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         last_r <= 1'b0;
         rise_cnt <= 8'h00;
      end else begin
         last_r <= irq_level;
         if (irq_level && !last_r) begin
            rise_cnt <= rise_cnt + 8'h01;
         end
      end
   end
endmodule // irq_host_model

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb
   import irq_status_pkg::*;
;
   logic core_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   event_in_t events;
   uart_in_t uart_in;
   wire logic awready, wready, bvalid, arready, rvalid, irq_level;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [7:0] rises;
   int checks, fails;

   bus_error_dma_interrupt_status bus_error_dma_interrupt_status_i (
      .core_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .events, .uart_in, .irq_level
   );
   irq_host_model irq_host_model_i (.core_clk, .sys_rst, .irq_level, .rise_cnt(rises));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   // bus values sampled at the falling edge, settled for the next rising
   // edge; ready comes a cycle late, so the slave must hold its answer
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ta;
      logic tw;
      logic seen;
      logic done;
      logic [1:0] r;
      done = 1'b0;
      r = 2'h0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(negedge core_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         seen = bvalid;
         done = bready && bvalid;
         r = bresp;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         bready <= seen && !done;
      end
      chk("bvalid", 32'd1, 32'(done));
      chk("bresp", 32'(er), 32'(r));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta;
      logic seen;
      logic done;
      logic [31:0] d;
      logic [1:0] r;
      done = 1'b0;
      d = 32'h0000_0000;
      r = 2'h0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(negedge core_clk);
         ta = arvalid && arready;
         seen = rvalid;
         done = rready && rvalid;
         d = rdata;
         r = rresp;
         @(posedge core_clk);
         if (ta) arvalid <= 1'b0;
         rready <= seen && !done;
      end
      chk("rvalid", 32'd1, 32'(done));
      chk("rdata", e, d);
      chk("rresp", 32'(er), 32'(r));
   endtask

   task automatic irq_is(input logic e);
      @(negedge core_clk);
      chk("irq_level", 32'(e), 32'(irq_level));
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_access();
      rd(ICR_OFS, ICR_RESET, RESP_OKAY);
      wr(ICR_OFS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      rd(ICR_OFS, 32'h008C_FF00, RESP_OKAY);
      wr(ICR_OFS, 32'h0000_0000, 4'h2, RESP_OKAY);
      rd(ICR_OFS, 32'h008C_0000, RESP_OKAY);
      wr(ICR_OFS, 32'h0000_0000, 4'hF, RESP_OKAY);
      wr(12'h054, 32'hFFFF_FFFF, 4'hF, RESP_DECERR);
      rd(12'h054, 32'h0000_0000, RESP_DECERR);
      rd(ICR_OFS, 32'h0000_0000, RESP_OKAY);
   endtask

   // each source: masked, enabled, zero clear, write-one clear
   task automatic t_events();
      int map [12] = '{7, 7, 7, 6, 5, 3, 4, 1, 2, 16, 17, 0};
      int eb, en, cl;
      for (int j = 0; j < 12; j++) begin
         eb = map[j];
         en = (eb < 8) ? eb + 8 : eb + 2;
         cl = (eb < 8) ? eb + 24 : eb + 4;
         @(posedge core_clk) events <= event_in_t'(12'h001 << j);
         @(posedge core_clk) events <= '0;
         @(posedge core_clk);
         irq_is(1'b0);
         rd(ICR_OFS, 32'h1 << eb, RESP_OKAY);
         wr(ICR_OFS, 32'h1 << en, 4'hF, RESP_OKAY);
         irq_is(1'b1);
         wr(ICR_OFS, 32'h1 << en, 4'hF, RESP_OKAY);
         rd(ICR_OFS, (32'h1 << eb) | (32'h1 << en), RESP_OKAY);
         wr(ICR_OFS, 32'h1 << cl, 4'hF, RESP_OKAY);
         irq_is(1'b0);
         rd(ICR_OFS, 32'h0000_0000, RESP_OKAY);
      end
   endtask

   task automatic t_uart();
      wr(ICR_OFS, 32'h0080_0000, 4'hF, RESP_OKAY);
      @(posedge core_clk) uart_in <= 5'b1_0000;
      rd(ICR_OFS, 32'h0080_0000, RESP_OKAY);
      irq_is(1'b0);
      @(posedge core_clk) uart_in <= 5'b1_0100;
      rd(ICR_OFS, 32'h00C0_0000, RESP_OKAY);
      irq_is(1'b1);
      wr(ICR_OFS, 32'h0000_0000, 4'hF, RESP_OKAY);
      irq_is(1'b0);
      rd(ICR_OFS, 32'h0040_0000, RESP_OKAY);
      @(posedge core_clk) uart_in <= '0;
   endtask

   task automatic final_report();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // clock, watchdog, main sequence
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // whole run is a few hundred cycles; this only catches a hang
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      final_report();
   end

   initial begin
      sys_rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      events = '0;
      uart_in = '0;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_access();
      t_events();
      t_uart();
      chk("irq_rises", 32'd13, 32'(rises));
      final_report();
   end
endmodule // tb
